// ==== pwmpc_pkg.sv ====
/*
 * Shared constants and carrier types for the paired PWM block.
 * Assumes a single clock domain and plain control ports, with no register bus.
 */
package pwmpc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths and values after reset.
    localparam int CNT_W = 16;
    localparam int PRE_W = 8;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] DUTY_RST = 16'h0000;
    localparam logic [CNT_W-1:0] PERIOD_RST = 16'hFFFF;
    localparam logic [PRE_W-1:0] PRE_RST = 8'h00;
    localparam logic FLAG_RST = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // Trigger action and edge codes.
    localparam logic [1:0] TRIG_SW = 2'h0;
    localparam logic [1:0] TRIG_START = 2'h1;
    localparam logic [1:0] TRIG_START_STOP = 2'h2;
    localparam logic [1:0] TRIG_CLEAR = 2'h3;
    localparam logic [1:0] EDGE_LEVEL = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_RISE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // Carrier types.
    typedef enum logic [2:0] {
        WR_NONE, WR_DUTY_HI, WR_DUTY_LO, WR_PER_HI, WR_PER_LO, WR_CNT_HI, WR_CNT_LO
    } pwmpc_wsel_type;

    typedef struct packed {
        pwmpc_wsel_type sel;
        logic [7:0] data;
    } pwmpc_wr_type;

    typedef struct packed {
        logic [1:0] clk_sel;
        logic clk_sel6;
        logic int_at_duty;
        logic invert;
        logic one_shot_select_bit;
        logic clear_ignore_in_duty;
        logic [1:0] trig_mode;
        logic [1:0] trig_edge;
        logic trigger_source_select;
    } pwmpc_cfg_type;

    typedef struct packed {
        logic start;
        logic stop;
        logic clear;
    } pwmpc_trig_type;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] dset;
        logic [CNT_W-1:0] pset;
        logic [CNT_W-1:0] dbuf;
        logic [CNT_W-1:0] pbuf;
        logic flag;
        logic run;
        logic stat;
    } pwmpc_chan_type;

endpackage : pwmpc_pkg

// ==== pwmpc_divider.sv ====
/*
 * Count clock divider: one-cycle tick per falling PWM clock edge.
 * Assumes ref_clk_i is the only clock; the selection is a static setting.
 */
`timescale 1ns/1ns
module pwmpc_divider #(
    parameter int PW = pwmpc_pkg::PRE_W
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [2:0] sel_i,
    output logic tick_o
);
    import pwmpc_pkg::*;

    if (PW < 7) begin : g_chk
        $error("Prescaler narrower than the largest division.");
    end

    typedef struct packed {
        logic [PW-1:0] cnt;
        logic tick;
    } pwmpc_div_type;

    pwmpc_div_type st;
    pwmpc_div_type next_st;

    ////////////////////////////////////////////////////////////////////////////////
    // Tick when the selected low bits of the prescaler are all ones.
    always_comb begin
        logic [PW-1:0] mask;
        mask = PW'((1 << sel_i) - 1);
        next_st.cnt = st.cnt + PW'(1);
        next_st.tick = ((st.cnt & mask) == mask);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;

endmodule : pwmpc_divider

// ==== pwmpc_trigger.sv ====
/*
 * External trigger decoder for one channel: start, stop and clear pulses.
 * Assumes the trigger pins are asynchronous and are synchronised here.
 */
`timescale 1ns/1ns
module pwmpc_trigger (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [1:0] pin_i,
    input pwmpc_pkg::pwmpc_cfg_type cfg_i,
    output pwmpc_pkg::pwmpc_trig_type trig_o
);
    import pwmpc_pkg::*;

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic prev;
        pwmpc_trig_type trig;
    } pwmpc_tst_type;

    pwmpc_tst_type st;
    pwmpc_tst_type next_st;

    ////////////////////////////////////////////////////////////////////////////////
    // Select the pin, find the chosen edge and map it to an action.
    always_comb begin
        logic cur;
        logic act;
        logic inact;
        cur = st.sync2[cfg_i.trigger_source_select];
        act = 1'b0;
        inact = 1'b0;
        next_st = st;
        next_st.sync1 = pin_i;
        next_st.sync2 = st.sync1;
        next_st.prev = cur;
        unique case (cfg_i.trig_edge)
            EDGE_LEVEL: begin
                act = cur;
                inact = !cur;
            end
            EDGE_FALL: begin
                act = st.prev && !cur;
                inact = !st.prev && cur;
            end
            EDGE_RISE: begin
                act = !st.prev && cur;
                inact = st.prev && !cur;
            end
            EDGE_BOTH: begin
                act = st.prev != cur;
            end
        endcase
        next_st.trig = '0;
        unique case (cfg_i.trig_mode)
            TRIG_SW: ;
            TRIG_START: next_st.trig.start = act;
            TRIG_START_STOP: begin
                next_st.trig.start = act;
                next_st.trig.stop = inact;
                next_st.trig.clear = inact;
            end
            TRIG_CLEAR: next_st.trig.clear = act;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign trig_o = st.trig;

endmodule : pwmpc_trigger

// ==== pwmpc_top.sv ====
/*
 * Paired 16-bit PWM with one-shot and coupled repeat operation.
 * Assumes software drives the write strobes and run bits as one-cycle pulses.
 */
`timescale 1ns/1ns
// Behaviour
// - Run: active flag first edge, count second
// - Duty match drives level low next edge
// - Period match sets level, clears counter
// - Period match reloads duty and period buffers
// - One-shot restarts only on a new run
// - Run cleared: one more edge, then halt
// - Rerun resumes from held counter value
// - Counter byte write clears counter, sets level
// - Stopped: setting writes pass into buffers
// - Clock, interrupt point, polarity from config
// - External input starts, stops or clears
// - Period setting+1, duty setting+1 cycles
// - First interrupt may slip one clock
// - Interrupt possible in the final edge
// - Clear ignored during duty when enabled
// - One-shot when uncoupled and bit set
// - Coupled repeat: first counter drives both
// - Coupled: second duty match drives low
// - Coupled: second period match drives high
// - Coupled: first period match restarts count
// - Coupled: second polarity from own config
module pwmpc_top (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input pwmpc_pkg::pwmpc_cfg_type [1:0] cfg_i,
    input wire logic pair_coupling_bit_i,
    input wire logic dead_time_enable_bit_i,
    input pwmpc_pkg::pwmpc_wr_type [1:0] wr_i,
    input wire logic [1:0] run_wr_i,
    input wire logic [1:0] run_wdata_i,
    input wire logic [1:0] trig_pin_i,
    output logic [1:0] pwm_o,
    output logic [1:0] output_level_flag_o,
    output logic [1:0] count_active_flag_o,
    output logic [1:0] run_request_bit_o,
    output logic [1:0] pwm_interrupt_o,
    output logic [1:0][pwmpc_pkg::CNT_W-1:0] counter_o
);
    import pwmpc_pkg::*;

    typedef struct packed {
        pwmpc_chan_type [1:0] ch;
        logic [1:0] intr;
        logic [1:0] pout;
    } pwmpc_top_type;

    pwmpc_top_type st;
    pwmpc_top_type next_st;
    logic [1:0] tick;
    pwmpc_trig_type [1:0] trig;
    logic coupled;

    function automatic pwmpc_chan_type reload(input pwmpc_chan_type c);
        reload = c;
        reload.dbuf = c.dset;
        reload.pbuf = c.pset;
    endfunction : reload

    ////////////////////////////////////////////////////////////////////////////////
    // Count clocks and trigger decoders, one per channel.
    for (genvar i = 0; i < 2; i++) begin : g_ch
        pwmpc_divider u_div (
            .ref_clk_i(ref_clk_i),
            .rstn_i(rstn_i),
            .sel_i({cfg_i[i].clk_sel6, cfg_i[i].clk_sel}),
            .tick_o(tick[i])
        );
        pwmpc_trigger u_trig (
            .ref_clk_i(ref_clk_i),
            .rstn_i(rstn_i),
            .pin_i(trig_pin_i),
            .cfg_i(cfg_i[i]),
            .trig_o(trig[i])
        );
    end

    // Dead-time operation is not served; with dead time set the channels run apart.
    assign coupled = pair_coupling_bit_i && !dead_time_enable_bit_i
        && !cfg_i[0].one_shot_select_bit;

    function automatic logic pair_pair_slave(input int i);
        pair_pair_slave = coupled && (i == 1);
    endfunction : pair_pair_slave

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        next_st = st;
        next_st.intr = '0;
        for (int i = 0; i < 2; i++) begin
            if (!(pair_pair_slave(i))) begin
                if (tick[i]) begin
                    if (!st.ch[i].stat) begin
                        next_st.ch[i].stat = st.ch[i].run;
                    end else begin
                        if (st.ch[i].cnt == st.ch[i].pbuf) begin
                            next_st.ch[i] = reload(st.ch[i]);
                            next_st.ch[i].flag = 1'b1;
                            next_st.ch[i].cnt = CNT_RST;
                            next_st.intr[i] = !cfg_i[i].int_at_duty;
                            if (cfg_i[i].one_shot_select_bit) begin
                                next_st.ch[i].run = 1'b0;
                                next_st.ch[i].stat = 1'b0;
                            end
                        end else begin
                            if (st.ch[i].cnt == st.ch[i].dbuf) begin
                                next_st.ch[i].flag = 1'b0;
                                next_st.intr[i] = cfg_i[i].int_at_duty;
                            end
                            next_st.ch[i].cnt = st.ch[i].cnt + CNT_W'(1);
                        end
                        if (!st.ch[i].run) begin
                            next_st.ch[i].stat = 1'b0;
                        end
                    end
                end
            end else if (tick[0] && st.ch[0].stat) begin
                if (st.ch[0].cnt == st.ch[1].pbuf) begin
                    next_st.ch[1].flag = 1'b1;
                end else if (st.ch[0].cnt == st.ch[1].dbuf) begin
                    next_st.ch[1].flag = 1'b0;
                end
                if (st.ch[0].cnt == st.ch[0].pbuf) begin
                    next_st.ch[1] = reload(next_st.ch[1]);
                end
            end
            if (trig[i].start) begin
                next_st.ch[i].run = 1'b1;
            end
            if (trig[i].stop) begin
                next_st.ch[i].run = 1'b0;
            end
            if (trig[i].clear && !(cfg_i[i].clear_ignore_in_duty && st.ch[i].flag)) begin
                next_st.ch[i] = reload(next_st.ch[i]);
                next_st.ch[i].cnt = CNT_RST;
                next_st.ch[i].flag = 1'b1;
            end
            if (run_wr_i[i]) begin
                next_st.ch[i].run = run_wdata_i[i];
            end
            unique case (wr_i[i].sel)
                WR_NONE: ;
                WR_DUTY_HI: next_st.ch[i].dset[15:8] = wr_i[i].data;
                WR_DUTY_LO: next_st.ch[i].dset[7:0] = wr_i[i].data;
                WR_PER_HI: next_st.ch[i].pset[15:8] = wr_i[i].data;
                WR_PER_LO: next_st.ch[i].pset[7:0] = wr_i[i].data;
                WR_CNT_HI, WR_CNT_LO: begin
                    next_st.ch[i].cnt = CNT_RST;
                    next_st.ch[i].flag = 1'b1;
                end
                default: ;
            endcase
            if (pair_pair_slave(i) ? !st.ch[0].stat : !st.ch[i].stat) begin
                next_st.ch[i].dbuf = next_st.ch[i].dset;
                next_st.ch[i].pbuf = next_st.ch[i].pset;
            end
            next_st.pout[i] = next_st.ch[i].flag ^ cfg_i[i].invert;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < 2; i++) begin
                st.ch[i].cnt <= CNT_RST;
                st.ch[i].dset <= DUTY_RST;
                st.ch[i].pset <= PERIOD_RST;
                st.ch[i].dbuf <= DUTY_RST;
                st.ch[i].pbuf <= PERIOD_RST;
                st.ch[i].flag <= FLAG_RST;
                st.ch[i].run <= 1'b0;
                st.ch[i].stat <= 1'b0;
            end
            st.intr <= '0;
            st.pout <= {FLAG_RST, FLAG_RST};
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.
    for (genvar i = 0; i < 2; i++) begin : g_out
        assign output_level_flag_o[i] = st.ch[i].flag;
        assign count_active_flag_o[i] = st.ch[i].stat;
        assign run_request_bit_o[i] = st.ch[i].run;
        assign counter_o[i] = st.ch[i].cnt;
    end
    assign pwm_o = st.pout;
    assign pwm_interrupt_o = st.intr;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on channel zero and the coupled pair.
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    logic quiet0;
    logic edge0;
    assign quiet0 = wr_i[0].sel == WR_NONE && trig[0] == '0 && !run_wr_i[0];
    assign edge0 = tick[0] && st.ch[0].stat && quiet0;

    property p_start_flag;
        !st.ch[0].stat && st.ch[0].run && tick[0] && quiet0
            |=> st.ch[0].stat && $stable(st.ch[0].cnt);
    endproperty
    a_start_flag: assert property (p_start_flag) else $error("Start edge misbehaved.");

    property p_duty_low;
        edge0 && st.ch[0].cnt == st.ch[0].dbuf && st.ch[0].cnt != st.ch[0].pbuf
            |=> !st.ch[0].flag;
    endproperty
    a_duty_low: assert property (p_duty_low) else $error("Duty match did not drop level.");

    property p_period_wrap;
        edge0 && st.ch[0].cnt == st.ch[0].pbuf |=> st.ch[0].flag && st.ch[0].cnt == CNT_RST;
    endproperty
    a_period_wrap: assert property (p_period_wrap) else $error("Period match failed.");

    property p_reload;
        edge0 && st.ch[0].cnt == st.ch[0].pbuf |=> st.ch[0].dbuf == $past(st.ch[0].dset);
    endproperty
    a_reload: assert property (p_reload) else $error("Buffer reload missing.");

    property p_one_shot;
        edge0 && st.ch[0].cnt == st.ch[0].pbuf && cfg_i[0].one_shot_select_bit
            |=> !st.ch[0].run && !st.ch[0].stat;
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("One-shot did not halt.");

    property p_stop;
        edge0 && !st.ch[0].run |=> !st.ch[0].stat;
    endproperty
    a_stop: assert property (p_stop) else $error("Stop took too long.");

    property p_cnt_write;
        wr_i[0].sel == WR_CNT_LO |=> st.ch[0].cnt == CNT_RST && st.ch[0].flag;
    endproperty
    a_cnt_write: assert property (p_cnt_write) else $error("Counter write ignored.");

    property p_direct;
        !st.ch[0].stat && wr_i[0].sel == WR_DUTY_LO |=> st.ch[0].dbuf[7:0] == $past(wr_i[0].data);
    endproperty
    a_direct: assert property (p_direct) else $error("Stopped write not passed.");

    property p_pair_low;
        coupled && tick[0] && st.ch[0].stat && wr_i[1].sel == WR_NONE && trig[1] == '0
            && st.ch[0].cnt == st.ch[1].dbuf && st.ch[0].cnt != st.ch[1].pbuf
            |=> !st.ch[1].flag;
    endproperty
    a_pair_low: assert property (p_pair_low) else $error("Second duty match missed.");

    property p_count_step;
        edge0 && st.ch[0].cnt != st.ch[0].pbuf
            |=> st.ch[0].cnt == $past(st.ch[0].cnt) + CNT_W'(1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("No count step.");

    property p_hold;
        !st.ch[0].stat && quiet0 |=> $stable(st.ch[0].cnt);
    endproperty
    a_hold: assert property (p_hold) else $error("Held count moved.");

    property p_int_duty;
        edge0 && st.ch[0].cnt == st.ch[0].dbuf && st.ch[0].cnt != st.ch[0].pbuf
            && cfg_i[0].int_at_duty |=> st.intr[0];
    endproperty
    a_int_duty: assert property (p_int_duty) else $error("Duty irq missing.");

    property p_int_period;
        edge0 && st.ch[0].cnt == st.ch[0].pbuf && !cfg_i[0].int_at_duty |=> st.intr[0];
    endproperty
    a_int_period: assert property (p_int_period) else $error("Period irq missing.");

    property p_pair_high;
        coupled && tick[0] && st.ch[0].stat && wr_i[1].sel == WR_NONE && trig[1] == '0
            && st.ch[0].cnt == st.ch[1].pbuf |=> st.ch[1].flag;
    endproperty
    a_pair_high: assert property (p_pair_high) else $error("Second high missed.");

    property p_pair_frozen;
        coupled && wr_i[1].sel == WR_NONE && trig[1] == '0 |=> $stable(st.ch[1].cnt);
    endproperty
    a_pair_frozen: assert property (p_pair_frozen) else $error("Second count moved.");

    property p_polarity;
        rstn_i |=> st.pout[1] == (st.ch[1].flag ^ $past(cfg_i[1].invert));
    endproperty
    a_polarity: assert property (p_polarity) else $error("Polarity wrong.");

    property p_trig_start;
        trig[0].start && !trig[0].stop && !run_wr_i[0] |=> st.ch[0].run;
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("Start ignored.");

    c_wrap: cover property (edge0 && st.ch[0].cnt == st.ch[0].pbuf);
    c_one_shot: cover property (cfg_i[0].one_shot_select_bit && $fell(st.ch[0].stat));
    c_pair: cover property (coupled && $fell(st.ch[1].flag));
    c_clear: cover property (trig[0].clear);
    c_duty_irq: cover property (cfg_i[0].int_at_duty && st.intr[0]);

endmodule : pwmpc_top

// ==== pwmpc_partner.sv ====
/*
 * Far-side model of the external trigger pins of the paired PWM block.
 * Assumes the testbench raises a request bit to ask for one high pulse on a pin.
 */
`timescale 1ns/1ns
module pwmpc_partner #(
    parameter int LEN = 20
) (
    input wire logic ref_clk_i,
    input wire logic [1:0] req_i,
    output logic [1:0] trig_pin_o
);
    logic [1:0] req_d = 2'h0;
    int cnt [2] = '{0, 0};

    ////////////////////////////////////////////////////////////////////////////////
    // Each new request gives one pulse of LEN clocks; the pin rests low otherwise.
    always @(posedge ref_clk_i) begin
        for (int i = 0; i < 2; i++) begin
            if (req_i[i] && !req_d[i]) begin
                cnt[i] <= LEN;
            end else if (cnt[i] > 0) begin
                cnt[i] <= cnt[i] - 1;
            end
        end
        req_d <= req_i;
    end

    always_comb begin
        trig_pin_o[0] = cnt[0] > 0;
        trig_pin_o[1] = cnt[1] > 0;
    end
endmodule : pwmpc_partner

// ==== pwmpc_tb_top.sv ====
/*
 * Self-checking testbench of the paired PWM block.
 * Assumes the count clock divides by one, so every clock is a count tick,
 * except in the one scenario that selects the rate of every second clock.
 */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module pwmpc_tb_top;
    import pwmpc_pkg::*;
    logic ref_clk_i;
    logic rstn_i = 1'b0;
    pwmpc_cfg_type [1:0] cfg = '0;
    logic pair = 1'b0;
    pwmpc_wr_type [1:0] wr = '0;
    logic [1:0] run_wr = 2'h0;
    logic [1:0] run_wd = 2'h0;
    logic [1:0] req = 2'h0;
    logic [1:0] pins;
    logic [1:0] pwm_o;
    logic [1:0] output_level_flag_o;
    logic [1:0] count_active_flag_o;
    logic [1:0] run_request_bit_o;
    logic [1:0] pwm_interrupt_o;
    logic [1:0][CNT_W-1:0] counter_o;
    int err_count = 0;
    int n_compared = 0;

    pwmpc_partner #(.LEN(20)) partner (.ref_clk_i(ref_clk_i), .req_i(req), .trig_pin_o(pins));

    pwmpc_top DUT (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cfg_i(cfg), .pair_coupling_bit_i(pair),
        .dead_time_enable_bit_i(1'b0), .wr_i(wr), .run_wr_i(run_wr), .run_wdata_i(run_wd),
        .trig_pin_i(pins), .pwm_o(pwm_o), .output_level_flag_o(output_level_flag_o),
        .count_active_flag_o(count_active_flag_o), .run_request_bit_o(run_request_bit_o),
        .pwm_interrupt_o(pwm_interrupt_o), .counter_o(counter_o)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared drivers and waits.
    task automatic wrb(input int ch, input pwmpc_wsel_type s, input logic [7:0] d);
        @(posedge ref_clk_i);
        wr[ch] <= '{s, d};
        @(posedge ref_clk_i);
        wr[ch] <= '{WR_NONE, 8'h00};
    endtask : wrb

    task automatic set16(input int ch, input pwmpc_wsel_type hi, input pwmpc_wsel_type lo,
                         input logic [15:0] v);
        wrb(ch, hi, v[15:8]);
        wrb(ch, lo, v[7:0]);
    endtask : set16

    task automatic run(input int ch, input logic v);
        @(posedge ref_clk_i);
        run_wr[ch] <= 1'b1;
        run_wd[ch] <= v;
        @(posedge ref_clk_i);
        run_wr[ch] <= 1'b0;
    endtask : run

    task automatic wt(input int k, input int ch, input logic lv, output int n);
        logic v;
        n = 0;
        do begin
            @(negedge ref_clk_i);
            n++;
            case (k)
                0: v = output_level_flag_o[ch];
                1: v = count_active_flag_o[ch];
                default: v = run_request_bit_o[ch];
            endcase
        end while (v !== lv && n < 300);
        if (n >= 300) begin
            err_count++;
            $display("Error wait %0d expected %0h seen %0h", k, lv, v);
        end
    endtask : wt

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_repeat;
        int n;
        set16(0, WR_DUTY_HI, WR_DUTY_LO, 16'h0002);
        set16(0, WR_PER_HI, WR_PER_LO, 16'h0009);
        run(0, 1'b1);
        wt(0, 0, 1'b0, n);
        wt(0, 0, 1'b1, n);
        `CHK("low_len", 7, n);
        `CHK("cnt_at_rise", 16'h0000, counter_o[0]);
        `CHK("irq_at_rise", 1'b1, pwm_interrupt_o[0]);
        wt(0, 0, 1'b0, n);
        `CHK("high_len", 3, n);
        wrb(0, WR_PER_LO, 8'h0C);
        wt(0, 0, 1'b1, n);
        wt(0, 0, 1'b0, n);
        wt(0, 0, 1'b1, n);
        `CHK("low_len_reload", 10, n);
    endtask : t_repeat

    task automatic t_stop;
        logic [15:0] h;
        int n;
        run(0, 1'b0);
        wt(1, 0, 1'b0, n);
        h = counter_o[0];
        repeat (5) @(negedge ref_clk_i);
        `CHK("held", h, counter_o[0]);
        run(0, 1'b1);
        n = 0;
        do begin
            @(negedge ref_clk_i);
            n++;
        end while (counter_o[0] === h && n < 20);
        `CHK("resume", (h == 16'h000C) ? 16'h0000 : h + 16'h0001, counter_o[0]);
        run(0, 1'b0);
        wt(1, 0, 1'b0, n);
        wrb(0, WR_CNT_LO, 8'h55);
        @(negedge ref_clk_i);
        `CHK("cnt_clear", 16'h0000, counter_o[0]);
        `CHK("flag_set", 1'b1, output_level_flag_o[0]);
    endtask : t_stop

    task automatic t_oneshot;
        int n;
        @(posedge ref_clk_i);
        cfg[1].one_shot_select_bit <= 1'b1;
        set16(1, WR_DUTY_HI, WR_DUTY_LO, 16'h0001);
        set16(1, WR_PER_HI, WR_PER_LO, 16'h0004);
        run(1, 1'b1);
        wt(1, 1, 1'b1, n);
        `CHK("start_hold", 16'h0000, counter_o[1]);
        @(negedge ref_clk_i);
        `CHK("start_count", 16'h0001, counter_o[1]);
        wt(2, 1, 1'b0, n);
        `CHK("os_cnt", 16'h0000, counter_o[1]);
        `CHK("os_flag", 1'b1, output_level_flag_o[1]);
        repeat (10) @(negedge ref_clk_i);
        `CHK("os_idle", 16'h0000, counter_o[1]);
        `CHK("os_stat", 1'b0, count_active_flag_o[1]);
        run(1, 1'b1);
        wt(1, 1, 1'b1, n);
        @(negedge ref_clk_i);
        `CHK("os_again", 16'h0001, counter_o[1]);
        wt(2, 1, 1'b0, n);
    endtask : t_oneshot

    task automatic t_coupled;
        int n;
        logic [15:0] c1;
        @(posedge ref_clk_i);
        cfg[1].one_shot_select_bit <= 1'b0;
        cfg[1].invert <= 1'b1;
        pair <= 1'b1;
        set16(1, WR_DUTY_HI, WR_DUTY_LO, 16'h0001);
        set16(1, WR_PER_HI, WR_PER_LO, 16'h0003);
        run(1, 1'b1);
        run(0, 1'b1);
        wt(0, 1, 1'b0, n);
        c1 = counter_o[1];
        `CHK("c_duty", 16'h0002, counter_o[0]);
        @(negedge ref_clk_i);
        `CHK("c_pol", 1'b1, pwm_o[1]);
        wt(0, 1, 1'b1, n);
        `CHK("c_per", 16'h0004, counter_o[0]);
        wt(0, 0, 1'b1, n);
        `CHK("c_wrap", 16'h0000, counter_o[0]);
        `CHK("c_run", 1'b1, count_active_flag_o[0]);
        `CHK("c_frozen", c1, counter_o[1]);
        run(0, 1'b0);
        wt(1, 0, 1'b0, n);
        run(1, 1'b0);
    endtask : t_coupled

    task automatic t_trigger;
        int n;
        @(posedge ref_clk_i);
        pair <= 1'b0;
        cfg[0].trig_mode <= TRIG_START_STOP;
        cfg[0].trig_edge <= EDGE_RISE;
        cfg[0].trigger_source_select <= 1'b1;
        req[1] <= 1'b1;
        wt(1, 0, 1'b1, n);
        `CHK("trig_start_wait", 1'b1, n <= 8);
        wt(1, 0, 1'b0, n);
        `CHK("trig_stop_wait", 1'b1, n <= 30);
        @(negedge ref_clk_i);
        // The clear lands with the stop, and one more edge is still counted.
        `CHK("trig_clear", 16'h0001, counter_o[0]);
        `CHK("trig_flag", 1'b1, output_level_flag_o[0]);
        @(posedge ref_clk_i);
        req[1] <= 1'b0;
    endtask : t_trigger

    task automatic t_slow;
        int n;
        @(posedge ref_clk_i);
        cfg[0].trig_mode <= TRIG_SW;
        cfg[0].clk_sel <= 2'h1;
        cfg[0].int_at_duty <= 1'b1;
        wrb(0, WR_CNT_HI, 8'h00);
        run(0, 1'b1);
        wt(0, 0, 1'b0, n);
        `CHK("irq_at_duty", 1'b1, pwm_interrupt_o[0]);
        wt(0, 0, 1'b1, n);
        `CHK("slow_low_len", 20, n);
        `CHK("slow_cnt_wrap", 16'h0000, counter_o[0]);
        run(0, 1'b0);
        wt(1, 0, 1'b0, n);
    endtask : t_slow

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, watchdog and main sequence.
    task automatic stop_test;
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        #2000000;
        err_count++;
        stop_test();
    end

    initial begin
        repeat (3) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        t_repeat();
        t_stop();
        t_oneshot();
        t_coupled();
        t_trigger();
        t_slow();
        stop_test();
    end
endmodule : pwmpc_tb_top
